/* rtl/qhp_pkg.sv */
// package: shared constants for the quad uart host bus port
package qhp_pkg;
    localparam int NUM_CH       = 4;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 3;
    localparam int CH_W         = 2;
    localparam int MCR_IRQ_EN_BIT = 3;
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;
    localparam logic [3:0] SETUP_LAST  = 4'h2; // last count of select setup before the strobe
    localparam logic [3:0] STROBE_LAST = 4'h8; // strobe covers pin sync plus read latency
    localparam logic [3:0] HOLD_LAST   = 4'h3; // last count of select hold after the strobe
endpackage

/* rtl/qhp_bus_if.sv */
// interface: pins between host and quad uart bus port
`timescale 1ns/1ps
`default_nettype none
interface qhp_bus_if;
    logic       bus_style_sel;      // high: separate strobes
    logic [2:0] addr;
    logic [7:0] data_host;
    logic       data_host_oe;
    logic [7:0] data_dev;
    logic       data_dev_oe;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       channel_a_select_n;
    logic       channel_b_select_n;
    logic       channel_c_select_n;
    logic       channel_d_select_n;
    logic       irq_force_select;
    logic [3:0] irq_out;            // channel_a..d_irq_out levels
    logic [3:0] irq_oe;
    logic       transmit_ready_n;
    logic       receive_ready_n;

    modport dev (
        input  bus_style_sel, addr, data_host, data_host_oe, read_strobe_n, write_strobe_n,
               channel_a_select_n, channel_b_select_n, channel_c_select_n, channel_d_select_n,
               irq_force_select,
        output data_dev, data_dev_oe, irq_out, irq_oe, transmit_ready_n, receive_ready_n
    );
    modport host (
        output bus_style_sel, addr, data_host, data_host_oe, read_strobe_n, write_strobe_n,
               channel_a_select_n, channel_b_select_n, channel_c_select_n, channel_d_select_n,
               irq_force_select,
        input  data_dev, data_dev_oe, irq_out, irq_oe, transmit_ready_n, receive_ready_n
    );
endinterface
`default_nettype wire

/* rtl/qhp_dev_port.sv */
// module: device end of the quad uart host bus port
// Behaviour
// [R01] style pin high selects separate strobes
// [R02] read strobe fall reads addressed register
// [R03] write strobe rise stores bus byte
// [R04] host holds read strobe high otherwise
// [R05] write pin is direction line otherwise
// [R06] per-channel selects enable their channel
// [R07] channel A select is single select
// [R08] selects B,C become address A3,A4
// [R09] board ties channel D select high
// [R10] modem control bit3 drives irq, else float
// [R11] channel A irq becomes open-drain active-low
// [R12] irq B,C,D held low otherwise
// [R13] transmit ready is AND of channels
// [R14] receive ready is AND of channels
// [R15] data bus driven only during reads
// [R16] force select enables all irq outputs
// [R17] A4:A3 value picks channel A..D
`timescale 1ns/1ps
`default_nettype none
module qhp_dev_port (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // bus pins
    qhp_bus_if.dev           bus,
    // channel register side
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic [1:0]       reg_ch_o,
    output logic [2:0]       reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic [3:0]  chan_irq_i,
    input  wire logic [3:0]  chan_tx_ready_n_i,
    input  wire logic [3:0]  chan_rx_ready_n_i,
    input  wire logic [31:0] modem_control_reg_i
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // every host pin is asynchronous to clk_sys_i; one shared two-stage chain
    // keeps address, data and strobes aligned, at a cost of two cycles of latency
    localparam int SW = 3 + 8 + 1 + 1 + 1 + 4 + 1 + 1;
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    // reset to all ones: strobes and selects idle high, style reads as separate
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '1;
            s2_r <= '1;
        end else begin
            s1_r <= {bus.addr, bus.data_host, bus.data_host_oe, bus.read_strobe_n, bus.write_strobe_n,
                     bus.channel_d_select_n, bus.channel_c_select_n, bus.channel_b_select_n,
                     bus.channel_a_select_n, bus.bus_style_sel, bus.irq_force_select};
            s2_r <= s1_r;
        end
    end
    logic [2:0] a_s;
    logic [7:0] d_s;
    logic       rd_n_s;
    logic       wr_n_s;
    logic       sty_s;
    logic       frc_s;
    logic [3:0] cs_n_s;
    // unpack the second stage; the host's own drive enable is carried but not used
    always_comb begin
        a_s    = s2_r[SW-1 -: 3];
        d_s    = s2_r[SW-4 -: 8];
        rd_n_s = s2_r[7];
        wr_n_s = s2_r[6];
        cs_n_s = s2_r[5:2];
        sty_s  = s2_r[1];
        frc_s  = s2_r[0];
    end

    // ************************************************************
    // decode of access
    // ************************************************************
    logic       sel;
    logic [1:0] ch;
    logic       rd_act;
    logic       wr_act;
    // access decode; a strobe with no select is refused in both styles
    always_comb begin
        sel    = 1'b0;
        ch     = qhp_pkg::CH_A;
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (sty_s) begin // [R01]
            // [R06] lowest selected channel wins if host selects several
            sel = ~&cs_n_s;
            if (!cs_n_s[0])      ch = qhp_pkg::CH_A;
            else if (!cs_n_s[1]) ch = qhp_pkg::CH_B;
            else if (!cs_n_s[2]) ch = qhp_pkg::CH_C;
            else                 ch = qhp_pkg::CH_D;
            rd_act = sel && !rd_n_s;   // [R02]
            wr_act = sel && !wr_n_s;   // [R03]
        end else begin
            sel    = !cs_n_s[0];                 // [R07]
            ch     = {cs_n_s[2], cs_n_s[1]};     // [R08] [R17]
            rd_act = sel && wr_n_s;              // [R05] read strobe ignored [R04]
            wr_act = sel && !wr_n_s;             // [R05]
        end
    end

    // ************************************************************
    // cycle tracking: one register pulse per access
    // ************************************************************
    logic       rd_prev_r;
    logic       wr_prev_r;
    logic [1:0] wch_r;
    logic [2:0] wad_r;
    logic [7:0] wdat_r;
    // previous access levels give the edges; the write target is captured while
    // the access stands because the selects may already be gone when it ends
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            wch_r     <= qhp_pkg::CH_A;
            wad_r     <= 3'h0;
            wdat_r    <= qhp_pkg::DATA_RESET;
        end else begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            // latch target while write is active; data taken at its end
            if (wr_act) begin
                wch_r  <= ch;
                wad_r  <= a_s;
                wdat_r <= d_s;
            end
        end
    end

    // register-side strobes: read at start, write at end of strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_wr_o    <= 1'b0;
            reg_rd_o    <= 1'b0;
            reg_ch_o    <= qhp_pkg::CH_A;
            reg_addr_o  <= 3'h0;
            reg_wdata_o <= qhp_pkg::DATA_RESET;
        end else begin
            reg_rd_o <= rd_act && !rd_prev_r;             // [R02]
            reg_wr_o <= !wr_act && wr_prev_r;             // [R03]
            if (rd_act && !rd_prev_r) begin
                reg_ch_o   <= ch;
                reg_addr_o <= a_s;
            end else if (!wr_act && wr_prev_r) begin
                reg_ch_o    <= wch_r;
                reg_addr_o  <= wad_r;
                reg_wdata_o <= wdat_r;
            end
        end
    end

    // ************************************************************
    // read data drive
    // ************************************************************
    logic       rd_pend_r;
    logic [7:0] rdat_r;
    // channel byte is held in a flop so the bus stays steady for the rest of the
    // strobe; a host strobe shorter than about six cycles would catch the old byte
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_r <= 1'b0;
            rdat_r    <= qhp_pkg::DATA_RESET;
        end else begin
            rd_pend_r <= reg_rd_o;
            if (rd_pend_r) rdat_r <= reg_rdata_i; // byte arrives one cycle after request
        end
    end
    // enable only while a read stands, so the two ends never drive together
    assign bus.data_dev    = rdat_r;
    assign bus.data_dev_oe = rd_act && rd_prev_r; // [R15]

    // ************************************************************
    // interrupt pins and ready outputs
    // ************************************************************
    logic [3:0] irq_lvl_r;
    logic [3:0] irq_en_r;
    // pin levels follow the channels one cycle late; the channel side runs on
    // clk_sys_i, so only the force and style pins needed a synchroniser
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_lvl_r <= 4'h0;
            irq_en_r  <= 4'h0;                  // all pins three-stated after reset [R10]
        end else if (sty_s) begin
            irq_lvl_r <= chan_irq_i;
            for (int i = 0; i < qhp_pkg::NUM_CH; i++) begin
                irq_en_r[i] <= frc_s | modem_control_reg_i[8*i + qhp_pkg::MCR_IRQ_EN_BIT]; // [R10] [R16]
            end
        end else begin
            // single device request: pin A only ever pulls low and the board
            // pull-up gives the high level; B to D drive a steady zero
            irq_lvl_r <= 4'h0;                  // [R11] [R12]
            irq_en_r  <= {3'b111, |chan_irq_i}; // [R11] [R12]
        end
    end
    assign bus.irq_out          = irq_lvl_r;
    assign bus.irq_oe           = irq_en_r;
    // combined ready pins: any channel ready pulls the shared line low
    assign bus.transmit_ready_n = &chan_tx_ready_n_i; // [R13]
    assign bus.receive_ready_n  = &chan_rx_ready_n_i; // [R14]
endmodule
`default_nettype wire

/* rtl/qhp_host_port.sv */
// module: host end driving the quad uart bus port
`timescale 1ns/1ps
`default_nettype none
module qhp_host_port (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // pins
    qhp_bus_if.host         bus,
    // user command side
    input  wire logic       style_sep_i,
    input  wire logic       force_irq_i,
    input  wire logic       req_i,
    input  wire logic       we_i,
    input  wire logic [1:0] ch_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic            busy_o,
    output logic            done_o,
    output logic [7:0]      rdata_o,
    output logic            irq_o,
    output logic            tx_ready_n_o,
    output logic            rx_ready_n_o
);
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} qhp_hst_t;
    qhp_hst_t   st_r;
    logic [3:0] cnt_r;
    logic       we_r;
    logic [1:0] ch_r;
    logic [2:0] ad_r;
    logic [7:0] wd_r;
    logic [1:0] tsy_r, rsy_r, isy_r;
    logic [7:0] dd1_r, dd2_r;

    // ************************************************************
    // sync of device pins
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tsy_r <= 2'b11;
            rsy_r <= 2'b11;
            isy_r <= 2'b00;
            dd1_r <= 8'h00;
            dd2_r <= 8'h00;
        end else begin
            tsy_r <= {tsy_r[0], bus.transmit_ready_n};
            rsy_r <= {rsy_r[0], bus.receive_ready_n};
            isy_r <= {isy_r[0], |(bus.irq_out & bus.irq_oe) | (!style_sep_i && bus.irq_oe[0] && !bus.irq_out[0])};
            dd1_r <= bus.data_dev;
            dd2_r <= dd1_r;
        end
    end
    assign irq_o        = isy_r[1];
    assign tx_ready_n_o = tsy_r[1];
    assign rx_ready_n_o = rsy_r[1];

    // ************************************************************
    // access sequencer
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r    <= ST_IDLE;
            cnt_r   <= 4'h0;
            we_r    <= 1'b0;
            ch_r    <= 2'h0;
            ad_r    <= 3'h0;
            wd_r    <= 8'h00;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            unique case (st_r)
                ST_IDLE: begin
                    if (req_i) begin
                        we_r  <= we_i;
                        ch_r  <= ch_i;
                        ad_r  <= addr_i;
                        wd_r  <= wdata_i;
                        cnt_r <= 4'h0;
                        st_r  <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == qhp_pkg::SETUP_LAST) begin
                        cnt_r <= 4'h0;
                        st_r  <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == qhp_pkg::STROBE_LAST) begin // sample read byte at strobe end
                        rdata_o <= dd2_r;
                        cnt_r   <= 4'h0;
                        st_r    <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == qhp_pkg::HOLD_LAST) begin
                        done_o <= 1'b1;
                        st_r   <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    assign busy_o = (st_r != ST_IDLE);

    // ************************************************************
    // pin drive per bus style
    // ************************************************************
    logic act, stb;
    always_comb begin
        act = (st_r != ST_IDLE);
        stb = (st_r == ST_STROBE);
        bus.bus_style_sel    = style_sep_i;
        bus.addr             = ad_r;
        bus.data_host        = wd_r;
        bus.data_host_oe     = act && we_r;
        bus.irq_force_select = style_sep_i && force_irq_i; // [R16]
        if (style_sep_i) begin
            bus.read_strobe_n      = !(stb && !we_r); // [R02]
            bus.write_strobe_n     = !(stb && we_r);  // [R03]
            bus.channel_a_select_n = !(act && ch_r == qhp_pkg::CH_A); // [R06]
            bus.channel_b_select_n = !(act && ch_r == qhp_pkg::CH_B);
            bus.channel_c_select_n = !(act && ch_r == qhp_pkg::CH_C);
            bus.channel_d_select_n = !(act && ch_r == qhp_pkg::CH_D);
        end else begin
            bus.read_strobe_n      = 1'b1;            // [R04]
            bus.write_strobe_n     = !(act && we_r);  // [R05]
            bus.channel_a_select_n = !stb;            // [R07]
            bus.channel_b_select_n = ch_r[0];         // [R08] [R17]
            bus.channel_c_select_n = ch_r[1];
            bus.channel_d_select_n = 1'b1;            // [R09]
        end
    end
endmodule
`default_nettype wire

/* sim/qhp_port_props.sv */
// checker: pin-level properties of the quad uart host bus port
`timescale 1ns/1ps
`default_nettype none
module qhp_port_props (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    // bus pins
    input wire logic       bus_style_sel_i,
    input wire logic       read_strobe_n_i,
    input wire logic       write_strobe_n_i,
    input wire logic       channel_a_select_n_i,
    input wire logic       channel_b_select_n_i,
    input wire logic       channel_c_select_n_i,
    input wire logic       channel_d_select_n_i,
    input wire logic       irq_force_select_i,
    input wire logic [3:0] irq_out_i,
    input wire logic [3:0] irq_oe_i,
    input wire logic       data_dev_oe_i,
    input wire logic       data_host_oe_i
);
    // ***************
    // properties
    // ***************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // pins pass two sync flops, so level antecedents hold four cycles before judging
    sequence rd_start_s;
        bus_style_sel_i && $fell(read_strobe_n_i) && !(channel_a_select_n_i && channel_b_select_n_i
            && channel_c_select_n_i && channel_d_select_n_i);
    endsequence
    sequence rd_answer_s;
        ##[1:8] data_dev_oe_i;
    endsequence
    sep_read_a: assert property (rd_start_s |-> rd_answer_s)
        else $error("read strobe gave no data drive");
    no_fight_a: assert property (!(data_dev_oe_i && data_host_oe_i))
        else $error("both ends drive data");
    sep_idle_a: assert property ((bus_style_sel_i && read_strobe_n_i)[*4] |-> !data_dev_oe_i)
        else $error("data driven without read strobe");
    no_select_a: assert property ((bus_style_sel_i && channel_a_select_n_i && channel_b_select_n_i
        && channel_c_select_n_i && channel_d_select_n_i)[*4] |-> !data_dev_oe_i)
        else $error("data driven without select");
    rw_write_a: assert property ((!bus_style_sel_i && !write_strobe_n_i)[*4] |-> !data_dev_oe_i)
        else $error("data driven during write");
    rw_select_a: assert property ((!bus_style_sel_i && channel_a_select_n_i)[*4] |-> !data_dev_oe_i)
        else $error("data driven without chip select");
    force_irq_a: assert property ((bus_style_sel_i && irq_force_select_i)[*4] |-> irq_oe_i == 4'hF)
        else $error("forced irq outputs not driven");
    rw_unused_a: assert property ((!bus_style_sel_i)[*4] |-> irq_out_i[3:1] == 3'h0)
        else $error("unused irq outputs not low");
    rw_drain_a: assert property ((!bus_style_sel_i)[*4] ##0 irq_oe_i[0] |-> !irq_out_i[0])
        else $error("open drain irq driven high");
endmodule
`default_nettype wire

/* sim/test_quad_uart_host_bus_port.sv */
// testbench: both ends of the quad uart host bus port joined by the bus interface
`timescale 1ns/1ps
`default_nettype none
module test_quad_uart_host_bus_port;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic style_sep = 1'b1, force_irq = 1'b0, req = 1'b0, we = 1'b0;
    logic [1:0] ch = 2'h0, reg_ch;
    logic [2:0] addr = 3'h0, reg_addr;
    logic [7:0] wdata = 8'h00, reg_wdata, rdata, reg_rdata = 8'h00;
    logic busy, done, irq, txr, rxr, reg_wr, reg_rd;
    logic [3:0] chan_irq = 4'h0, chan_tx = 4'hF, chan_rx = 4'hF;
    logic [31:0] modem_control_reg = 32'h0;
    logic [12:0] wr_log = 13'h0;
    int err_count = 0, num_checks = 0;
    qhp_bus_if bus_if ();
    qhp_dev_port u_qhp_dev_port (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus_if),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_ch_o(reg_ch), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .chan_irq_i(chan_irq),
        .chan_tx_ready_n_i(chan_tx), .chan_rx_ready_n_i(chan_rx), .modem_control_reg_i(modem_control_reg));
    qhp_host_port u_qhp_host_port (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus_if),
        .style_sep_i(style_sep), .force_irq_i(force_irq), .req_i(req), .we_i(we), .ch_i(ch),
        .addr_i(addr), .wdata_i(wdata), .busy_o(busy), .done_o(done), .rdata_o(rdata),
        .irq_o(irq), .tx_ready_n_o(txr), .rx_ready_n_o(rxr));
    qhp_port_props u_qhp_port_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .bus_style_sel_i(bus_if.bus_style_sel), .read_strobe_n_i(bus_if.read_strobe_n),
        .write_strobe_n_i(bus_if.write_strobe_n), .channel_a_select_n_i(bus_if.channel_a_select_n),
        .channel_b_select_n_i(bus_if.channel_b_select_n), .channel_c_select_n_i(bus_if.channel_c_select_n),
        .channel_d_select_n_i(bus_if.channel_d_select_n), .irq_force_select_i(bus_if.irq_force_select),
        .irq_out_i(bus_if.irq_out), .irq_oe_i(bus_if.irq_oe), .data_dev_oe_i(bus_if.data_dev_oe),
        .data_host_oe_i(bus_if.data_host_oe));
    // ***************
    // clock and channel register stand-in
    // ***************
    initial forever #10 clk_sys_i = ~clk_sys_i;
    // read byte encodes channel and register so a wrong decode shows in the data
    always @(posedge clk_sys_i) begin
        if (reg_rd === 1'b1) reg_rdata <= {reg_ch, reg_addr, 3'h5};
        if (reg_wr === 1'b1) wr_log <= {reg_ch, reg_addr, reg_wdata};
    end
    // ***************
    // tasks
    // ***************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (e !== g) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one host access; bounded wait on done, sampled mid-cycle
    task automatic acc(input logic w, input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        we <= w;
        ch <= c;
        addr <= a;
        wdata <= d;
        req <= 1'b1;
        @(posedge clk_sys_i);
        req <= 1'b0;
        @(negedge clk_sys_i);
        chk("busy", 16'h1, {15'h0, busy});
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (done !== 1'b1 && n < 60);
        if (done !== 1'b1) begin
            err_count++;
            results();
        end
        chk("idle", 16'h0, {15'h0, busy});
        if (w) chk("write", {3'h0, c, a, d}, {3'h0, wr_log});
        else chk("read", {8'h0, c, a, 3'h5}, {8'h0, rdata});
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    // ***************
    // main sequence
    // ***************
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, c[1:0], 3'(c + 1), 8'hA0 + 8'(c));
            acc(1'b0, c[1:0], 3'(7 - c), 8'h00);
        end
        // separate style irq enables, one channel at a time, then forced
        @(posedge clk_sys_i);
        chan_irq <= 4'hF;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys_i);
            modem_control_reg <= 32'h8 << (8 * c);
            wait_n(4);
            chk("irq_oe", 16'(1 << c), {12'h0, bus_if.irq_oe});
            chk("host irq", 16'h1, {15'h0, irq});
        end
        @(posedge clk_sys_i);
        modem_control_reg <= 32'h0;
        force_irq <= 1'b1;
        wait_n(4);
        chk("irq_oe forced", 16'hF, {12'h0, bus_if.irq_oe});
        @(posedge clk_sys_i) force_irq <= 1'b0;
        wait_n(4);
        chk("irq_oe off", 16'h0, {12'h0, bus_if.irq_oe});
        // read/write-line style: chip select plus A4:A3 channel lines
        @(posedge clk_sys_i) style_sep <= 1'b0;
        chan_irq <= 4'h0;
        wait_n(4);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, c[1:0], 3'(c + 2), 8'h5C ^ 8'(c));
            acc(1'b0, c[1:0], 3'(c), 8'h00);
        end
        chk("unused strobes", 16'h3, {14'h0, bus_if.read_strobe_n, bus_if.channel_d_select_n});
        chk("unused irq", 16'h0E, {9'h0, bus_if.irq_out[3:1], bus_if.irq_oe[3:1], 1'b0});
        chk("host irq idle", 16'h0, {15'h0, irq});
        @(posedge clk_sys_i) chan_irq <= 4'h4;
        wait_n(4);
        chk("device irq", 16'h1, {14'h0, bus_if.irq_out[0], bus_if.irq_oe[0]});
        chk("host irq pulled", 16'h1, {15'h0, irq});
        // combined ready outputs over every status pattern
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys_i);
            chan_tx <= 4'(i);
            chan_rx <= ~4'(i);
            @(negedge clk_sys_i);
            chk("tx ready", {15'h0, (i == 15)}, {15'h0, bus_if.transmit_ready_n});
            chk("rx ready", {15'h0, (i == 0)}, {15'h0, bus_if.receive_ready_n});
            // host end sees the pins through two flops
            wait_n(2);
            chk("tx ready out", {15'h0, (i == 15)}, {15'h0, txr});
            chk("rx ready out", {15'h0, (i == 0)}, {15'h0, rxr});
        end
        results();
    end
endmodule
`default_nettype wire
